// File: include/ccs_pkg.sv
// Package for the CAN interrupt pending and clock stop block
package ccs_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam int          CCS_MAX_CH      = 2;
  localparam logic [7:0]  CCS_OFF_PEND0   = 8'h00;  // Channel pending, next channel +4
  localparam logic [7:0]  CCS_OFF_MASK0   = 8'h08;  // Channel mask, next channel +4
  localparam logic [7:0]  CCS_OFF_STOP    = 8'h10;  // Global stop
  localparam logic [7:0]  CCS_CH_STRIDE   = 8'h04;
  localparam int          CCS_STOP_BIT    = 15;     // Clock stop bit position
  localparam logic [15:0] CCS_STOP_RESET  = 16'h0000;
  localparam logic [4:0]  CCS_PEND_RESET  = 5'h00;
  localparam logic [3:0]  CCS_STRB_HALF   = 4'h3;   // Low 16-bit lanes

  // ************************************************************
  // Carrier types
  // ************************************************************
  // Bit order equals the flag positions 4..0 of the pending register
  typedef struct packed {
    logic wakeup;
    logic rx_err_passive;
    logic tx_err_passive_busoff;
    logic rx_done;
    logic tx_done;
  } ccs_evt_type;

  typedef struct packed {
    ccs_evt_type [CCS_MAX_CH-1:0] pend;
    ccs_evt_type [CCS_MAX_CH-1:0] mask;
    logic                         stop;
    logic                         rx_s1;
    logic                         rx_s2;
    logic                         rx_s3;
    logic                         wake;
    logic [31:0]                  prdata;
    logic                         pslverr;
    logic                         err_acc;
  } ccs_state_type;

endpackage

// File: rtl/ccs_top.sv
// CAN channel interrupt pending flags and global clock stop, APB slave
`timescale 1ns/1ns
`default_nettype none

// Function
// - Wakeup flag reads 1 while a wakeup interrupt from sleep is pending.
// - Receive error passive flag reads 1 while its interrupt is pending.
// - Global stop register is written only as a full 16-bit word; reads take any strobe.
// - Stop bit 0 supplies subsystem clock; 1 stops it.
// - A bus change while stopped can wake the CPU.
// - Writing 1 clears a pending flag; writing 0 leaves it.
// - Flags set only when enabled; disabling does not clear them.
module ccs_top
  import ccs_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [7:0]                   i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  input  wire logic [3:0]                   i_pstrb,
  output logic                              o_pready,
  output logic [31:0]                       o_prdata,
  output logic                              o_pslverr,
  input  wire ccs_evt_type [CCS_MAX_CH-1:0] i_evt,
  input  wire ccs_evt_type [CCS_MAX_CH-1:0] i_evt_en,
  input  wire logic                         i_can_rx,
  output logic                              o_subsys_clk_en,
  output logic                              o_cpu_wakeup,
  output logic                              o_irq
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (NUM_CH < 1 || NUM_CH > CCS_MAX_CH) begin : g_bad_ch
    $error("NUM_CH must be between 1 and CCS_MAX_CH");
  end

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0]    rst_sync_reg;
  logic          rst_n;
  ccs_state_type st_reg;
  ccs_state_type st_next;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic setup_ph;
  logic acc_wr;
  logic sel_stop;
  logic sel_pend [CCS_MAX_CH];
  logic sel_mask [CCS_MAX_CH];
  logic hit;

  assign setup_ph = i_psel & ~i_penable;
  assign acc_wr   = i_psel & i_penable & i_pwrite & ~st_reg.err_acc;

  // Address match for each register
  always_comb begin
    sel_stop = (i_paddr == CCS_OFF_STOP);
    hit      = sel_stop;
    for (int c = 0; c < CCS_MAX_CH; c++) begin
      sel_pend[c] = (c < NUM_CH) &&
                    (i_paddr == CCS_OFF_PEND0 + CCS_CH_STRIDE * 8'(c));
      sel_mask[c] = (c < NUM_CH) &&
                    (i_paddr == CCS_OFF_MASK0 + CCS_CH_STRIDE * 8'(c));
      hit         = hit | sel_pend[c] | sel_mask[c];
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    // CAN receive line passes two flops, third flop feeds the edge check
    st_next.rx_s1 = i_can_rx;
    st_next.rx_s2 = st_reg.rx_s1;
    st_next.rx_s3 = st_reg.rx_s2;

    // Setup phase: check access and capture read data
    if (setup_ph) begin
      st_next.prdata  = 32'h0;
      st_next.err_acc = 1'b0;
      if (!hit) begin
        st_next.err_acc = 1'b1;
      end else if (st_reg.stop && !sel_stop) begin
        st_next.err_acc = 1'b1;  // Refused while stopped
      end else if (sel_stop && i_pwrite && i_pstrb != CCS_STRB_HALF) begin
        st_next.err_acc = 1'b1;  // Only a whole 16-bit write
      end else if (sel_stop) begin
        st_next.prdata[CCS_STOP_BIT] = st_reg.stop;
      end else begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (sel_pend[c]) begin
            st_next.prdata[4:0] = st_reg.pend[c];
          end else if (sel_mask[c]) begin
            st_next.prdata[4:0] = st_reg.mask[c];
          end
        end
      end
      st_next.pslverr = st_next.err_acc;
    end

    // Access phase writes
    if (acc_wr && sel_stop) begin
      st_next.stop = i_pwdata[CCS_STOP_BIT];
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (acc_wr && sel_mask[c]) begin
        st_next.mask[c] = ccs_evt_type'(i_pwdata[4:0]);
      end
      // Write-one clears, then enabled events set; set wins
      if (acc_wr && sel_pend[c]) begin
        st_next.pend[c] = st_reg.pend[c] & ~ccs_evt_type'(i_pwdata[4:0]);
      end
      // Set only when enabled, never cleared by disable
      st_next.pend[c] = st_next.pend[c] | (i_evt[c] & i_evt_en[c]);
    end

    // Bus activity while stopped raises wakeup until restart
    if (!st_reg.stop) begin
      st_next.wake = 1'b0;
    end else if (st_reg.rx_s2 != st_reg.rx_s3) begin
      st_next.wake = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg         <= '0;
      st_reg.stop    <= CCS_STOP_RESET[CCS_STOP_BIT];
      st_reg.rx_s1   <= 1'b1;
      st_reg.rx_s2   <= 1'b1;
      st_reg.rx_s3   <= 1'b1;
      for (int c = 0; c < CCS_MAX_CH; c++) begin
        st_reg.pend[c] <= ccs_evt_type'(CCS_PEND_RESET);
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic irq_any;
  always_comb begin
    irq_any = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      irq_any = irq_any | (|(st_reg.pend[c] & st_reg.mask[c]));
    end
  end

  assign o_pready        = 1'b1;  // Zero-wait slave
  assign o_prdata        = st_reg.prdata;
  assign o_pslverr       = st_reg.pslverr & i_psel & i_penable;
  assign o_subsys_clk_en = ~st_reg.stop;
  assign o_cpu_wakeup    = st_reg.wake;
  assign o_irq           = irq_any;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  chk_wake_set: assert property (
    (i_evt[0].wakeup && i_evt_en[0].wakeup) |=> st_reg.pend[0].wakeup)
    else $error("wakeup flag not set by enabled event");
  chk_rxerr_set: assert property (
    (i_evt[0].rx_err_passive && i_evt_en[0].rx_err_passive)
      |=> st_reg.pend[0].rx_err_passive)
    else $error("receive error passive flag not set");
  chk_txerr_hold: assert property (
    (st_reg.pend[0].tx_err_passive_busoff && !(acc_wr && sel_pend[0]))
      |=> st_reg.pend[0].tx_err_passive_busoff)
    else $error("transmit error flag dropped without a clear");
  chk_done_set: assert property (
    (i_evt[0].rx_done && i_evt_en[0].rx_done && i_evt[0].tx_done
      && i_evt_en[0].tx_done) |=> (st_reg.pend[0].rx_done && st_reg.pend[0].tx_done))
    else $error("completion flags not set");
  chk_stop_strobe: assert property (
    (setup_ph && sel_stop && i_pwrite && i_pstrb != CCS_STRB_HALF)
      ##1 (i_psel && i_penable) |=> $stable(st_reg.stop))
    else $error("partial write changed the stop register");
  chk_clk_gate: assert property (
    (acc_wr && sel_stop) |=> (o_subsys_clk_en == !$past(i_pwdata[CCS_STOP_BIT])))
    else $error("clock enable does not follow stop bit");
  chk_stop_refuse: assert property (
    (setup_ph && st_reg.stop && !sel_stop) ##1 (i_psel && i_penable) |-> o_pslverr)
    else $error("access while stopped not refused");
  chk_wake_edge: assert property (
    (st_reg.stop && (st_reg.rx_s2 != st_reg.rx_s3)) |=> o_cpu_wakeup)
    else $error("bus change while stopped gave no wakeup");
  chk_w1c_clear: assert property (
    (acc_wr && sel_pend[0] && i_pwdata[0] && !(i_evt[0].tx_done && i_evt_en[0].tx_done))
      |=> !st_reg.pend[0].tx_done)
    else $error("write one did not clear flag");
  chk_set_gated: assert property (
    (!st_reg.pend[0].rx_done && !(i_evt[0].rx_done && i_evt_en[0].rx_done))
      |=> !st_reg.pend[0].rx_done)
    else $error("flag set without enabled event");
  chk_irq_level: assert property (
    (st_reg.pend[0].wakeup && st_reg.mask[0].wakeup) |-> o_irq)
    else $error("unmasked pending flag gave no interrupt");

  cov_stop_wake: cover property (st_reg.stop ##[1:50] o_cpu_wakeup);
  cov_irq: cover property (!o_irq ##1 o_irq);
  cov_refused: cover property (o_pslverr);
  cov_set_clear_same: cover property (acc_wr && sel_pend[0] && |i_evt[0]);

endmodule

`default_nettype wire

// File: verification/ccs_can_bus_model.sv
// Behavioural CAN bus seen through a line transceiver
`timescale 1ns/1ns
`default_nettype none
module ccs_can_bus_model #(
  parameter int BIT_CYC = 4
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sof,
  output logic      o_can_rx
);
  int cnt = 0;
  // Counts one dominant bit after a start-of-frame request
  always_ff @(posedge i_clk_sys) begin
    if (i_sof) begin
      cnt <= BIT_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Transceiver pulls the line recessive (high) when nobody drives it
  assign o_can_rx = (cnt == 0);
endmodule
`default_nettype wire

// File: verification/ccs_top_bench.sv
// Self-checking bench for the CAN pending flags and clock stop block
`timescale 1ns/1ns
`default_nettype none
module ccs_top_bench
  import ccs_pkg::*;
;
  typedef struct {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic [31:0] rdata;
    logic        err;
  } ccs_row_type;
  logic                         clk = 0;
  logic                         rst_n = 0;
  logic                         psel = 0;
  logic                         penable = 0;
  logic                         pwrite = 0;
  logic                         sof = 0;
  logic [7:0]                   paddr = 0;
  logic [31:0]                  pwdata = 0;
  logic [3:0]                   pstrb = 0;
  ccs_evt_type [CCS_MAX_CH-1:0] evt = '0;
  ccs_evt_type [CCS_MAX_CH-1:0] en = '0;
  logic                         o_pready, o_pslverr, can_rx, o_clk_en, o_wake, o_irq;
  logic [31:0]                  o_prdata, rd;
  logic                         er;
  int                           err_count = 0;
  int                           cmp_count = 0;
  ccs_row_type                  rows [9] = '{
    '{0, 8'h00, 0, 0, 32'h0, 0},         // pending ch0 after reset
    '{0, 8'h04, 0, 0, 32'h0, 0},         // pending ch1 after reset
    '{1, 8'h08, 32'h1f, 4'hf, 0, 0},     // mask ch0 all
    '{0, 8'h08, 0, 0, 32'h1f, 0},
    '{1, 8'h0c, 32'h03, 4'hf, 0, 0},     // mask ch1 low two
    '{0, 8'h0c, 0, 0, 32'h03, 0},
    '{0, 8'h14, 0, 0, 32'h0, 1},         // unmapped
    '{1, 8'h10, 32'h8000, 4'h1, 0, 1},   // half stop write refused
    '{0, 8'h10, 0, 0, 32'h0, 0}};
  ccs_top #(.NUM_CH(2)) dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_evt(evt), .i_evt_en(en), .i_can_rx(can_rx), .o_subsys_clk_en(o_clk_en),
    .o_cpu_wakeup(o_wake), .o_irq(o_irq));
  ccs_can_bus_model bus (.i_clk_sys(clk), .i_sof(sof), .o_can_rx(can_rx));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    // Answer taken at the rising edge where pready is sampled high
    do @(posedge clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    chk(o_clk_en, 1);
    chk(o_pready, 1);
    chk(o_irq, 0);
    chk(o_wake, 0);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rows[i].strb);
      if (!rows[i].wr) chk(rd, rows[i].rdata);
      chk(er, rows[i].err);
    end
    // Events on both channels, only channel 0 enabled
    en <= 10'h01f;
    @(posedge clk);
    evt <= 10'h3ff;
    @(posedge clk);
    evt <= 10'h000;
    @(negedge clk);
    chk(o_irq, 1);
    apb(0, 8'h00, 0, 0);
    chk(rd, 32'h1f);
    apb(0, 8'h04, 0, 0);
    chk(rd, 32'h0);
    en <= '0;
    apb(1, 8'h00, 32'h05, 4'hf);
    apb(0, 8'h00, 0, 0);
    chk(rd, 32'h1a);
    apb(1, 8'h00, 32'h1a, 4'hf);
    apb(0, 8'h00, 0, 0);
    chk(rd, 32'h0);
    chk(o_irq, 0);
    // A clear that meets a held receive completion event: the set wins
    en <= 10'h002;
    evt <= 10'h002;
    apb(1, 8'h00, 32'h1f, 4'hf);
    evt <= 10'h000;
    en <= '0;
    apb(0, 8'h00, 0, 0);
    chk(rd, 32'h02);
    chk(o_irq, 1);
    apb(1, 8'h00, 32'h02, 4'hf);
    apb(0, 8'h00, 0, 0);
    chk(rd, 32'h0);
    chk(o_irq, 0);
    // Initialise and global operation live outside this block; then stop
    apb(1, CCS_OFF_STOP, 32'h8000, CCS_STRB_HALF);
    chk(er, 0);
    @(negedge clk);
    chk(o_clk_en, 0);
    apb(0, 8'h00, 0, 0);
    chk(er, 1);
    apb(0, CCS_OFF_STOP, 0, 0);
    chk(rd, 32'h8000);
    sof <= 1;
    @(posedge clk);
    sof <= 0;
    repeat (20) @(posedge clk) if (o_wake === 1'b1) break;
    chk(o_wake, 1);
    apb(1, CCS_OFF_STOP, 32'h0, CCS_STRB_HALF);
    @(negedge clk);
    chk(o_clk_en, 1);
    // Wakeup drops one cycle after the stop bit has gone
    @(negedge clk);
    chk(o_wake, 0);
    // Flags set while stopped, then a second reset clears everything
    apb(1, CCS_OFF_STOP, 32'h8000, CCS_STRB_HALF);
    en <= 10'h3ff;
    evt <= 10'h3ff;
    @(posedge clk);
    evt <= 10'h000;
    en <= '0;
    @(negedge clk);
    chk(o_irq, 1);
    @(posedge clk);
    rst_n <= 0;
    repeat (3) @(posedge clk);
    chk(o_irq, 0);
    chk(o_clk_en, 1);
    chk(o_pslverr, 0);
    chk(o_wake, 0);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    apb(0, 8'h00, 0, 0);
    chk(rd, 32'h0);
    apb(0, 8'h08, 0, 0);
    chk(rd, 32'h0);
    apb(0, CCS_OFF_STOP, 0, 0);
    chk(rd, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
